// >>> scb_blinker.sv
// scb_pkg: constants shared by the switch/blink block, and scb_blinker, the run lamp sequencer.
// assumes one 40 MHz clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

package scb_pkg;
    // *****************************************
    // clock and blink timing
    // *****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int BLINK_ON_MS = 250;
    localparam int BLINK_OFF_MS = 250;
    localparam int BLINK_GAP_MS = 1500;
    localparam int BLINK_ON_CYC = CLK_HZ / 1000 * BLINK_ON_MS;
    localparam int BLINK_OFF_CYC = CLK_HZ / 1000 * BLINK_OFF_MS;
    localparam int BLINK_GAP_CYC = CLK_HZ / 1000 * BLINK_GAP_MS;

    // *****************************************
    // slide switch positions as seen on the pins
    // *****************************************
    localparam logic [1:0] POS_TOP = 2'h1;
    localparam logic [1:0] POS_MID = 2'h2;
    localparam logic [1:0] POS_BOT = 2'h3;

    // *****************************************
    // serial settings
    // *****************************************
    localparam logic [3:0] BAUD_50 = 4'h0; // steps 50..19200 in rising order
    localparam logic [3:0] BAUD_2400 = 4'ha;
    localparam logic [3:0] BAUD_9600 = 4'he;
    localparam logic [3:0] BAUD_19200 = 4'hf;
    localparam logic [7:0] SER_ADDR_MIN = 8'h01;
    localparam logic [7:0] SER_ADDR_MAX = 8'hf7; // 247
    localparam logic [7:0] ROT_ADDR_MAX = 8'h40; // 64
    localparam logic [3:0] DIGIT_MAX = 4'h9;

    // *****************************************
    // register map and fields
    // *****************************************
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_SERCFG = 8'h08;
    localparam logic [7:0] REG_SERADDR = 8'h0c;
    localparam logic [7:0] REG_EFFECT = 8'h10;
    localparam logic [7:0] REG_FAULT = 8'h14;
    localparam int ST_FAULT = 0;
    localparam int ST_BADADDR = 1;
    localparam int ST_SWCHG = 2;
    localparam int CFG_PAR_EN = 4;
    localparam int CFG_PAR_ODD = 5;
    localparam int CFG_DATA8 = 6;
    localparam int CFG_STOP2 = 7;
    localparam logic [7:0] SERCFG_RST = 8'h5e; // 9600, parity even, 8 data, 1 stop
    localparam logic [7:0] SERADDR_RST = 8'h01;

    typedef enum logic [1:0] {SCB_IDLE, SCB_ON, SCB_OFF, SCB_GAP} scb_blink_t;

    // crash code to blink count, zero when the code has no blink group
    function automatic logic [3:0] scb_blinks(input logic [15:0] code);
        if (code >= 16'h0604 && code <= 16'h0631) begin
            return 4'h4;
        end else if (code == 16'h0503 || code == 16'h052d) begin
            return 4'h5;
        end else if (code == 16'h0402) begin
            return 4'h6;
        end else if (code == 16'h0300 || code == 16'h0301) begin
            return 4'h7;
        end else if (code >= 16'h8001 && code <= 16'h8fff) begin
            return 4'h8;
        end
        return 4'h0;
    endfunction
endpackage

module scb_blinker #(
    parameter int ON_CYC = scb_pkg::BLINK_ON_CYC,
    parameter int OFF_CYC = scb_pkg::BLINK_OFF_CYC,
    parameter int GAP_CYC = scb_pkg::BLINK_GAP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // request
    input wire logic [3:0] blinks,
    input wire logic run_in,
    // lamp
    output logic lamp
);
    import scb_pkg::*;

    scb_blink_t state_reg;
    logic [31:0] cnt_reg;
    logic [3:0] left_reg;

    // group of short blinks, then a long dark gap so groups can be counted
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= SCB_IDLE;
            cnt_reg <= 32'h0;
            left_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                SCB_IDLE: begin
                    if (blinks != 4'h0) begin
                        state_reg <= SCB_ON;
                        cnt_reg <= 32'(ON_CYC - 1);
                        left_reg <= blinks;
                    end
                end
                SCB_ON: begin
                    if (cnt_reg == 32'h0) begin
                        state_reg <= SCB_OFF;
                        cnt_reg <= 32'(OFF_CYC - 1);
                        left_reg <= left_reg - 4'h1;
                    end else begin
                        cnt_reg <= cnt_reg - 32'h1;
                    end
                end
                SCB_OFF: begin
                    if (cnt_reg != 32'h0) begin
                        cnt_reg <= cnt_reg - 32'h1;
                    end else if (left_reg == 4'h0) begin
                        state_reg <= SCB_GAP;
                        cnt_reg <= 32'(GAP_CYC - 1);
                    end else begin
                        state_reg <= SCB_ON;
                        cnt_reg <= 32'(ON_CYC - 1);
                    end
                end
                SCB_GAP: begin
                    if (cnt_reg == 32'h0) begin
                        state_reg <= SCB_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 32'h1;
                    end
                end
            endcase
        end
    end

    // lamp follows the run state until a fault group takes it over
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lamp <= 1'b0;
        end else if (blinks != 4'h0) begin
            lamp <= (state_reg == SCB_ON);
        end else begin
            lamp <= run_in;
        end
    end

    // the gap after a group is dark for longer than any single off time
    property p_gap_dark;
        @(posedge clk) disable iff (!arst_n)
        (state_reg == SCB_OFF && cnt_reg == 32'h0 && left_reg == 4'h0 && blinks != 4'h0)
            |=> (state_reg == SCB_GAP && cnt_reg == 32'(GAP_CYC - 1)) ##1 !lamp;
    endproperty
    a_gap_dark: assert property (p_gap_dark) else $error("blink gap missing");
endmodule

`default_nettype wire

// >>> scb_switch_cfg.sv
// scb_switch_cfg: front/rear switch decode, serial settings, address check and fault lamp.
// assumes switch pins are asynchronous to clk; fault reports come from logic on clk.
//
// Overview of operation
// - Left slide switch on top turns memory write protection on, middle or bottom off.
// - Right switch on top fixes the serial port at ASCII, 2400 baud, even parity, 7 data, 1 stop.
// - Right switch in the middle fixes the serial port at RTU, 9600 baud, even, 8 data, 1 stop.
// - Right switch at the bottom takes serial settings, address 1 to 247, from software.
// - Either fixed mode turns on bridge mode so a panel device can reach network nodes.
// - In the fixed modes the serial device address is the rotary switch value.
// - The rotary value is the network node address, and in the fixed modes also the serial address.
// - The rotary value is ten times the tens selector plus the ones selector.
// - Only addresses up to 64 are valid, so with tens at 6 only ones 0 to 4 are valid.
// - Address 0 or above 64 holds the network lamp steadily on.
// - Communication faults 604 to 631 blink the run lamp four times.
// - Memory address or self-test faults blink five times, memory data fault 402 six.
// - Missing or bad executive firmware blinks seven, boot and flash faults 8001 up eight.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module scb_switch_cfg #(
    parameter int ON_CYC = scb_pkg::BLINK_ON_CYC,
    parameter int OFF_CYC = scb_pkg::BLINK_OFF_CYC,
    parameter int GAP_CYC = scb_pkg::BLINK_GAP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // switch pins
    input wire logic [1:0] protect_switch,
    input wire logic [1:0] mode_switch,
    input wire logic [3:0] tens_address_selector,
    input wire logic [3:0] ones_address_selector,
    // diagnostics and run state
    input wire logic fault_valid,
    input wire logic [15:0] fault_code,
    input wire logic solving,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // serial port settings
    output logic ser_ascii,
    output logic [3:0] ser_baud,
    output logic ser_par_en,
    output logic ser_par_odd,
    output logic ser_data8,
    output logic ser_stop2,
    output logic [7:0] ser_addr,
    // system outputs
    output logic mem_protect,
    output logic bridge_mode,
    output logic [7:0] node_addr,
    output logic net_lamp_force,
    output logic run_lamp,
    output logic irq
);
    import scb_pkg::*;

    // ******************************
    // pin synchronisers
    // ******************************
    logic [11:0] pin_meta_reg;
    logic [11:0] pin_sync_reg;
    logic [1:0] prot_s;
    logic [1:0] mode_s;
    logic [3:0] tens_s;
    logic [3:0] ones_s;

    // two flops on every switch pin; only the second one is used below
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_reg <= 12'h0;
            pin_sync_reg <= 12'h0;
        end else begin
            pin_meta_reg <= {protect_switch, mode_switch, tens_address_selector,
                ones_address_selector};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign {prot_s, mode_s, tens_s, ones_s} = pin_sync_reg;

    // ******************************
    // rotary address
    // ******************************
    logic [7:0] rot_addr;
    logic rot_ok;

    // digits above 9 cannot form a decimal address and count as invalid
    assign rot_addr = 8'({4'h0, tens_s} * 8'h0a) + {4'h0, ones_s};
    assign rot_ok = (tens_s <= DIGIT_MAX) && (ones_s <= DIGIT_MAX) && (rot_addr != 8'h0)
        && (rot_addr <= ROT_ADDR_MAX);

    // ******************************
    // registers written by software
    // ******************************
    logic [2:0] status_reg;
    logic [2:0] status_next;
    logic [2:0] mask_reg;
    logic [7:0] sercfg_reg;
    logic [7:0] seraddr_reg;
    logic [15:0] fault_reg;
    logic fault_held_reg;
    logic [3:0] blink_cnt_reg;
    logic [3:0] sw_prev_reg;
    logic bad_prev_reg;
    logic [2:0] event_set;

    // software settings; an address outside 1..247 is refused and the old one kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sercfg_reg <= SERCFG_RST;
            seraddr_reg <= SERADDR_RST;
            mask_reg <= 3'h0;
        end else if (reg_wr) begin
            if (reg_addr == REG_SERCFG) begin
                sercfg_reg <= reg_wdata[7:0];
            end
            if (reg_addr == REG_SERADDR && reg_wdata[7:0] >= SER_ADDR_MIN
                && reg_wdata[7:0] <= SER_ADDR_MAX) begin
                seraddr_reg <= reg_wdata[7:0];
            end
            if (reg_addr == REG_MASK) begin
                mask_reg <= reg_wdata[2:0];
            end
        end
    end

    // ******************************
    // fault capture
    // ******************************
    // the first fault with a blink group is kept until reset: a crash is final
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_reg <= 16'h0;
            fault_held_reg <= 1'b0;
            blink_cnt_reg <= 4'h0;
        end else if (fault_valid && !fault_held_reg && scb_blinks(fault_code) != 4'h0) begin
            fault_reg <= fault_code;
            fault_held_reg <= 1'b1;
            blink_cnt_reg <= scb_blinks(fault_code);
        end
    end

    // ******************************
    // events, status and interrupt
    // ******************************
    assign event_set[ST_FAULT] = fault_valid && !fault_held_reg
        && scb_blinks(fault_code) != 4'h0;
    assign event_set[ST_BADADDR] = !rot_ok && !bad_prev_reg;
    assign event_set[ST_SWCHG] = {prot_s, mode_s} != sw_prev_reg;

    // write one to clear; an event in the same cycle wins over the clear
    always_comb begin
        status_next = status_reg;
        if (reg_wr && reg_addr == REG_STATUS) begin
            status_next = status_reg & ~reg_wdata[2:0];
        end
        status_next = status_next | event_set;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= 3'h0;
            irq <= 1'b0;
            sw_prev_reg <= 4'h0;
            bad_prev_reg <= 1'b1;
        end else begin
            status_reg <= status_next;
            irq <= |(status_next & mask_reg);
            sw_prev_reg <= {prot_s, mode_s};
            bad_prev_reg <= !rot_ok;
        end
    end

    // ******************************
    // switch decode to outputs
    // ******************************
    // an undefined switch code counts as bottom: no protection, software settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_protect <= 1'b0;
            node_addr <= 8'h0;
            net_lamp_force <= 1'b1;
        end else begin
            mem_protect <= (prot_s == POS_TOP);
            node_addr <= rot_addr;
            net_lamp_force <= !rot_ok;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ser_ascii <= 1'b0;
            ser_baud <= SERCFG_RST[3:0];
            ser_par_en <= SERCFG_RST[CFG_PAR_EN];
            ser_par_odd <= SERCFG_RST[CFG_PAR_ODD];
            ser_data8 <= SERCFG_RST[CFG_DATA8];
            ser_stop2 <= SERCFG_RST[CFG_STOP2];
            ser_addr <= SERADDR_RST;
            bridge_mode <= 1'b0;
        end else if (mode_s == POS_TOP) begin
            ser_ascii <= 1'b1;
            ser_baud <= BAUD_2400;
            ser_par_en <= 1'b1;
            ser_par_odd <= 1'b0;
            ser_data8 <= 1'b0;
            ser_stop2 <= 1'b0;
            ser_addr <= rot_addr;
            bridge_mode <= 1'b1;
        end else if (mode_s == POS_MID) begin
            ser_ascii <= 1'b0;
            ser_baud <= BAUD_9600;
            ser_par_en <= 1'b1;
            ser_par_odd <= 1'b0;
            ser_data8 <= 1'b1;
            ser_stop2 <= 1'b0;
            ser_addr <= rot_addr;
            bridge_mode <= 1'b1;
        end else begin
            ser_ascii <= 1'b0;
            ser_baud <= sercfg_reg[3:0];
            ser_par_en <= sercfg_reg[CFG_PAR_EN];
            ser_par_odd <= sercfg_reg[CFG_PAR_ODD];
            ser_data8 <= sercfg_reg[CFG_DATA8];
            ser_stop2 <= sercfg_reg[CFG_STOP2];
            ser_addr <= seraddr_reg;
            bridge_mode <= 1'b0;
        end
    end

    // ******************************
    // register read
    // ******************************
    // read data stand for exactly one cycle; unmapped offsets read zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: reg_rdata <= {29'h0, status_reg};
                REG_MASK: reg_rdata <= {29'h0, mask_reg};
                REG_SERCFG: reg_rdata <= {24'h0, sercfg_reg};
                REG_SERADDR: reg_rdata <= {24'h0, seraddr_reg};
                REG_EFFECT: reg_rdata <= {rot_ok, 2'h0, mem_protect, bridge_mode, ser_ascii,
                    ser_stop2, ser_data8, ser_par_odd, ser_par_en, ser_baud, 2'h0, ser_addr,
                    node_addr};
                REG_FAULT: reg_rdata <= {fault_held_reg, 11'h0, blink_cnt_reg, fault_reg};
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ******************************
    // run lamp
    // ******************************
    scb_blinker #(
        .ON_CYC(ON_CYC),
        .OFF_CYC(OFF_CYC),
        .GAP_CYC(GAP_CYC)
    ) u_blink (
        .clk(clk),
        .arst_n(arst_n),
        .blinks(blink_cnt_reg),
        .run_in(solving),
        .lamp(run_lamp)
    );

    // ******************************
    // checks
    // ******************************
    property p_protect;
        @(posedge clk) disable iff (!arst_n)
        ##1 mem_protect == ($past(prot_s) == POS_TOP);
    endproperty
    a_protect: assert property (p_protect) else $error("protect mismatch");

    property p_ascii;
        @(posedge clk) disable iff (!arst_n)
        (mode_s == POS_TOP) |=> (ser_ascii && ser_baud == BAUD_2400 && ser_par_en
            && !ser_par_odd && !ser_data8 && !ser_stop2);
    endproperty
    a_ascii: assert property (p_ascii) else $error("ascii settings wrong");

    property p_rtu;
        @(posedge clk) disable iff (!arst_n)
        (mode_s == POS_MID) |=> (!ser_ascii && ser_baud == BAUD_9600 && ser_par_en
            && !ser_par_odd && ser_data8 && !ser_stop2);
    endproperty
    a_rtu: assert property (p_rtu) else $error("rtu settings wrong");

    property p_soft;
        @(posedge clk) disable iff (!arst_n)
        (mode_s == POS_BOT) |=> (ser_baud == $past(sercfg_reg[3:0]) && ser_addr >= SER_ADDR_MIN
            && ser_addr <= SER_ADDR_MAX && !bridge_mode);
    endproperty
    a_soft: assert property (p_soft) else $error("software settings not applied");

    property p_bridge;
        @(posedge clk) disable iff (!arst_n)
        (mode_s == POS_TOP || mode_s == POS_MID) |=> bridge_mode && ser_addr == $past(rot_addr);
    endproperty
    a_bridge: assert property (p_bridge) else $error("bridge or address wrong");

    property p_node;
        @(posedge clk) disable iff (!arst_n)
        ##1 node_addr == 8'({4'h0, $past(tens_s)} * 8'h0a) + {4'h0, $past(ones_s)};
    endproperty
    a_node: assert property (p_node) else $error("node address wrong");

    property p_invalid;
        @(posedge clk) disable iff (!arst_n)
        (tens_s == 4'h6 && ones_s == 4'h5) || (tens_s == 4'h0 && ones_s == 4'h0)
            |=> net_lamp_force;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid address not shown");

    property p_valid;
        @(posedge clk) disable iff (!arst_n)
        (tens_s == 4'h6 && ones_s == 4'h4) |=> !net_lamp_force;
    endproperty
    a_valid: assert property (p_valid) else $error("address 64 refused");

    property p_comm_fault;
        @(posedge clk) disable iff (!arst_n)
        (fault_valid && !fault_held_reg && fault_code == 16'h0604) |=> blink_cnt_reg == 4'h4;
    endproperty
    a_comm_fault: assert property (p_comm_fault) else $error("comm fault count wrong");

    property p_flash_fault;
        @(posedge clk) disable iff (!arst_n)
        (fault_valid && !fault_held_reg && fault_code == 16'h8002) |=> blink_cnt_reg == 4'h8;
    endproperty
    a_flash_fault: assert property (p_flash_fault) else $error("flash fault count wrong");

    c_ascii: cover property (@(posedge clk) disable iff (!arst_n) mode_s == POS_TOP ##1 ser_ascii);
    c_fault: cover property (@(posedge clk) disable iff (!arst_n) status_reg[ST_FAULT] && irq);
    c_bad: cover property (@(posedge clk) disable iff (!arst_n) $rose(net_lamp_force));
endmodule

`default_nettype wire

// >>> scb_panel_model.sv
// scb_panel_model: slide switches, rotary selectors and a run lamp observer.
// assumes the bench sets switch positions and the lamp changes on clk.
`timescale 1ns/1ps
`default_nettype none

module scb_panel_model #(
    parameter int TH = 8
) (
    // bench side
    input wire logic clk,
    input wire logic clr,
    input wire logic [1:0] prot_pos,
    input wire logic [1:0] mode_pos,
    input wire logic [3:0] tens,
    input wire logic [3:0] ones,
    output logic [3:0] group_cnt,
    output logic [15:0] gap_len,
    // pins
    input wire logic run_lamp,
    output logic [1:0] protect_switch,
    output logic [1:0] mode_switch,
    output logic [3:0] tens_address_selector,
    output logic [3:0] ones_address_selector
);
    int cnt;
    int dark;
    logic prev;

    // contacts are always driven, so the pins never float
    assign protect_switch = prot_pos;
    assign mode_switch = mode_pos;
    assign tens_address_selector = tens;
    assign ones_address_selector = ones;

    // a dark run past TH ends a group; the next rise records how long it was
    always @(posedge clk) begin
        prev <= run_lamp;
        if (clr) begin
            cnt <= 0;
            dark <= 0;
            group_cnt <= 4'h0;
            gap_len <= 16'h0;
        end else if (run_lamp && !prev) begin
            cnt <= (dark > TH) ? 1 : cnt + 1;
            if (dark > TH && group_cnt != 4'h0) begin
                gap_len <= 16'(dark);
            end
            dark <= 0;
        end else if (!run_lamp) begin
            dark <= dark + 1;
            if (dark == TH && cnt != 0) begin
                group_cnt <= 4'(cnt);
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
// tb_top: self-checking bench for the switch decode and blink block.
// assumes short blink counts and the panel model on the far side.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import scb_pkg::*;
    localparam int ON_C = 4;
    localparam int OFF_C = 4;
    localparam int GAP_C = 20;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clr = 1'b1;
    logic [1:0] prot_pos = POS_BOT;
    logic [1:0] mode_pos = POS_TOP;
    logic [3:0] tens = 4'h1;
    logic [3:0] ones = 4'h1;
    logic fault_valid = 1'b0;
    logic [15:0] fault_code = 16'h0;
    logic solving = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [1:0] protect_switch, mode_switch;
    logic [3:0] tens_address_selector, ones_address_selector, ser_baud, group_cnt;
    logic [7:0] ser_addr, node_addr;
    logic [15:0] gap_len;
    logic ser_ascii, ser_par_en, ser_par_odd, ser_data8, ser_stop2;
    logic mem_protect, bridge_mode, net_lamp_force, run_lamp, irq;
    logic [9:0] ser_vec;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int node;
    logic [15:0] codes [7] = '{16'h0700, 16'h0604, 16'h0631, 16'h052d, 16'h0402, 16'h0301, 16'h8002};
    int nblk [7] = '{0, 4, 4, 5, 6, 7, 8};
    int rt [5] = '{1, 6, 6, 0, 0};
    int ro [5] = '{1, 5, 4, 0, 1};

    assign ser_vec = {ser_ascii, ser_baud, ser_par_en, ser_par_odd, ser_data8, ser_stop2, bridge_mode};

    always #12.5 clk = ~clk;

    scb_switch_cfg #(.ON_CYC(ON_C), .OFF_CYC(OFF_C), .GAP_CYC(GAP_C)) DUT (
        .clk, .arst_n, .protect_switch, .mode_switch, .tens_address_selector,
        .ones_address_selector, .fault_valid, .fault_code, .solving, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .ser_ascii, .ser_baud, .ser_par_en, .ser_par_odd,
        .ser_data8, .ser_stop2, .ser_addr, .mem_protect, .bridge_mode, .node_addr,
        .net_lamp_force, .run_lamp, .irq);

    scb_panel_model #(.TH(2 * OFF_C)) panel (
        .clk, .clr, .prot_pos, .mode_pos, .tens, .ones, .group_cnt, .gap_len, .run_lamp,
        .protect_switch, .mode_switch, .tens_address_selector, .ones_address_selector);

    // ****************
    // access tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                          input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, exp, what);
    endtask

    // switch pins pass two sync stages, so give them a few edges
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        clr <= 1'b1;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        clr <= 1'b0;
        settle();
    endtask

    task automatic fault(input logic [15:0] c);
        @(posedge clk);
        fault_valid <= 1'b1;
        fault_code <= c;
        @(posedge clk);
        fault_valid <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // a hung wait ends here instead of running on
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ****************
    // test sequence
    // ****************
    initial begin
        do_reset();
        rd_chk(REG_SERCFG, '1, 32'h5e, "sercfg reset");
        rd_chk(REG_SERADDR, '1, 32'h1, "seraddr reset");
        rd_chk(8'h18, '1, 32'h0, "unmapped read");
        for (int i = 1; i < 4; i++) begin
            prot_pos <= 2'(i);
            settle();
            chk(32'(mem_protect), 32'(i == 1), "mem protect");
        end
        // software settings must not leak into the fixed modes
        wr(REG_SERCFG, 32'hbf);
        settle();
        chk(32'(ser_vec), 32'h351, "ascii fixed");
        chk(32'(ser_addr), 32'd11, "fixed address");
        mode_pos <= POS_MID;
        settle();
        chk(32'(ser_vec), 32'h1d5, "rtu fixed");
        mode_pos <= POS_BOT;
        settle();
        chk(32'(ser_vec), 32'h1fa, "software cfg");
        wr(REG_SERADDR, 32'hf7);
        wr(REG_SERADDR, 32'hf8);
        wr(REG_SERADDR, 32'h0);
        settle();
        chk(32'(ser_addr), 32'hf7, "software address");
        rd_chk(REG_EFFECT, '1, 32'h82fcf70b, "effect view");
        // alternate valid and invalid addresses so each invalid one is a fresh event
        mode_pos <= POS_TOP;
        settle();
        rd_chk(REG_STATUS, 32'h4, 32'h4, "switch change");
        wr(REG_STATUS, 32'h7);
        wr(REG_MASK, 32'h2);
        rd_chk(REG_MASK, '1, 32'h2, "mask readback");
        for (int i = 0; i < 5; i++) begin
            tens <= 4'(rt[i]);
            ones <= 4'(ro[i]);
            settle();
            node = 10 * rt[i] + ro[i];
            chk(32'(node_addr), 32'(node), "node address");
            chk(32'(ser_addr), 32'(node), "serial address");
            chk(32'(net_lamp_force), 32'(node == 0 || node > 64), "address check");
            chk(32'(irq), 32'(node == 0 || node > 64), "irq raised");
            wr(REG_STATUS, 32'h7);
            settle();
            chk(32'(irq), 32'h0, "irq cleared");
        end
        wr(REG_MASK, 32'h0);
        ones <= 4'h0;
        settle();
        chk(32'(irq), 32'h0, "irq masked");
        rd_chk(REG_STATUS, 32'h2, 32'h2, "status sticky");
        solving <= 1'b1;
        settle();
        chk(32'(run_lamp), 32'h1, "run lamp");
        solving <= 1'b0;
        // each code needs a reset, since the first fault is held
        for (int i = 0; i < 7; i++) begin
            do_reset();
            fault(codes[i]);
            if (nblk[i] == 0) begin
                settle();
                rd_chk(REG_FAULT, '1, 32'h0, "ungrouped code");
                continue;
            end
            fault(16'h8001);
            for (int k = 0; k < 2000 && gap_len == 16'h0; k++) begin
                @(posedge clk);
            end
            chk(32'(group_cnt), 32'(nblk[i]), "blink count");
            chk(32'(gap_len >= GAP_C), 32'h1, "group gap");
            rd_chk(REG_FAULT, '1, {1'b1, 11'h0, 4'(nblk[i]), codes[i]}, "held fault");
            rd_chk(REG_STATUS, 32'h1, 32'h1, "fault status");
        end
        print_verdict();
    end
endmodule
`default_nettype wire
